// File: design/dma_split_mode_channel.sv
// Notes on behaviour
// - indexed destination takes frame index only after last receive-write element of frame.
// - frame_end_flag in secondary control sets once per frame, even in split mode.
// - split mode runs transmit src-to-split and receive (split+4)-to-dst halves.
// - element count reloads into transfer counter after last element of frame.
// - synced receive write waits own sync; transmit reads stall until it finishes.
// - paused split channel resumes and completes outstanding receive transfer on restart.
// - dma_precedence_bit decides peripheral_bus arbitration; zero lets the CPU win.
// - four channels, zero to three, all with identical multiframe split behaviour.
// - word, half-word and byte elements; address steps by size or by index.
// - element index is a byte count independent of the element size.
`timescale 1ns/1ps
`include "dma_split_regs.svh"

module dma_split_mode_channel #(
    parameter int NCH = 4
) (
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    input  wire logic [NCH-1:0] rd_sync,
    input  wire logic [NCH-1:0] wr_sync,
    input  wire logic        cpu_peripheral_bus_req,
    output logic             cpu_peripheral_bus_gnt,
    output logic             mem_req,
    output logic             mem_we,
    output logic [31:0]      mem_addr,
    output logic [31:0]      mem_wdata,
    output logic [1:0]       mem_size,
    output logic             mem_peripheral_bus,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    output logic [NCH-1:0]   frame_event
);
    // sync pins from outside the clock domain
    logic [NCH-1:0] rs_a_ff, rs_b_ff, ws_a_ff, ws_b_ff;
    logic [NCH-1:0] rs_c_ff, ws_c_ff;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rs_a_ff <= '0;
            rs_b_ff <= '0;
            rs_c_ff <= '0;
            ws_a_ff <= '0;
            ws_b_ff <= '0;
            ws_c_ff <= '0;
        end else begin
            rs_a_ff <= rd_sync;
            rs_b_ff <= rs_a_ff;
            rs_c_ff <= rs_b_ff;
            ws_a_ff <= wr_sync;
            ws_b_ff <= ws_a_ff;
            ws_c_ff <= ws_b_ff;
        end
    end
    // rising edges of the synchronised sync events
    wire [NCH-1:0] r_edge = rs_b_ff & ~rs_c_ff;
    wire [NCH-1:0] w_edge = ws_b_ff & ~ws_c_ff;

    // per-channel registers
    logic [31:0] prim_ff  [NCH];
    logic [3:0]  sec_ff   [NCH];
    logic [31:0] src_ff   [NCH];
    logic [31:0] dst_ff   [NCH];
    logic [31:0] split_ff [NCH];
    logic [31:0] cnt_ff   [NCH];   // [15:0] element count, [31:16] frame count
    logic [15:0] ecur_ff  [NCH];
    logic [15:0] rxcur_ff [NCH];
    logic [15:0] fcur_ff  [NCH];
    logic [31:0] idx_ff   [NCH];   // [15:0] element index, [31:16] frame index
    logic [31:0] data_ff  [NCH];
    logic [NCH-1:0] rpend_ff, wpend_ff;
    dma_split_pkg::xfer_state_e st_ff [NCH];
    logic [NCH-1:0] irq_st_ff, irq_mk_ff;

    logic [1:0]  cur_ff;
    logic        busy_ff;
    logic [31:0] rdata_ff;
    logic        ack_bus_ff;
    logic        wreq_ff;

    // bus decode
    wire         bus_req   = (avs_read | avs_write) & ~ack_bus_ff;
    wire         is_chan   = (avs_address[7] == 1'b0);
    wire [1:0]   bus_ch    = avs_address[6:5];
    wire [3:0]   bus_reg   = {1'b0, avs_address[4:2]};
    wire         wr_fire   = avs_write & ack_bus_ff;
    wire         bus_done  = st_ff[bus_ch] == dma_split_pkg::ST_DONE;
    wire         bus_act   = !bus_done && st_ff[bus_ch] != dma_split_pkg::ST_IDLE;
    wire         wr_stat   = wr_fire & (avs_address == `ADR_IRQ_STATUS);
    wire         wr_mask   = wr_fire & (avs_address == `ADR_IRQ_MASK);

    // element step and active channel fields
    function automatic logic [31:0] step_of(input logic [1:0] dir, input logic [1:0] esz,
                                           input logic [15:0] eidx);
        logic [31:0] sz;
        sz = (esz == `ESIZE_WORD) ? 32'h4 : (esz == `ESIZE_HALF) ? 32'h2 : 32'h1;
        case (dir)
            `DIR_INC:   step_of = sz;
            `DIR_DEC:   step_of = 32'h0 - sz;
            `DIR_INDEX: step_of = {{16{eidx[15]}}, eidx};
            default:    step_of = 32'h0;
        endcase
    endfunction : step_of

    wire [31:0] c_prim  = prim_ff[cur_ff];
    wire [1:0]  c_esz   = c_prim[`PRI_ESIZE_LSB +: 2];
    wire [1:0]  c_sdir  = c_prim[`PRI_SDIR_LSB +: 2];
    wire [1:0]  c_ddir  = c_prim[`PRI_DDIR_LSB +: 2];
    wire        c_split = c_prim[`PRI_SPLIT_BIT];
    wire        c_sync  = c_prim[`PRI_SYNC_BIT];
    wire [15:0] c_eidx  = idx_ff[cur_ff][15:0];
    wire [15:0] c_fidx  = idx_ff[cur_ff][31:16];
    wire [31:0] s_step  = step_of(c_sdir, c_esz, c_eidx);
    wire [31:0] d_step  = step_of(c_ddir, c_esz, c_eidx);
    wire        c_lastf = (fcur_ff[cur_ff] <= 16'h1);
    wire [31:0] d_fstep = (c_ddir == `DIR_INDEX) ? {{16{c_fidx[15]}}, c_fidx} : d_step;
    wire        c_peripheral_bus  = src_ff[cur_ff][31:28] == 4'h1;
    wire [31:0] c_rxsrc = split_ff[cur_ff] + 32'h4;
    wire        c_spbus = split_ff[cur_ff][31:28] == 4'h1;
    wire        c_dpbus = dst_ff[cur_ff][31:28] == 4'h1;
    // precedence bit decides; zero lets a pending cpu access win
    wire        cpu_wins = cpu_peripheral_bus_req & ~c_prim[`PRI_PREC_BIT];
    wire        mem_go   = mem_req & mem_ack;

    // fixed priority pick of a started, unpaused channel; lowest number wins
    logic [1:0] pick;
    logic       pick_ok;
    always_comb begin
        pick    = cur_ff;
        pick_ok = 1'b0;
        for (int k = NCH - 1; k >= 0; k--) begin
            if (prim_ff[k][`PRI_START_BIT] && !prim_ff[k][`PRI_PAUSE_BIT]
                && st_ff[k] != dma_split_pkg::ST_IDLE && st_ff[k] != dma_split_pkg::ST_DONE) begin
                pick    = 2'(k);
                pick_ok = 1'b1;
            end
        end
    end

    // bus answer: one wait cycle, then data with waitrequest low
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ack_bus_ff <= 1'b0;
            wreq_ff    <= 1'b1;
            rdata_ff   <= `RST_ZERO;
        end else begin
            ack_bus_ff <= bus_req;
            wreq_ff    <= ~bus_req;
            if (avs_address == `ADR_IRQ_STATUS)
                rdata_ff <= {{(32-NCH){1'b0}}, irq_st_ff};
            else if (avs_address == `ADR_IRQ_MASK)
                rdata_ff <= {{(32-NCH){1'b0}}, irq_mk_ff};
            else if (!is_chan)
                rdata_ff <= `RST_ZERO;
            else begin
                case (bus_reg)
                    `OFS_PRIMARY:   rdata_ff <= prim_ff[bus_ch];
                    `OFS_SECONDARY: rdata_ff <= {28'h0, bus_act, bus_done, sec_ff[bus_ch][1:0]};
                    `OFS_SRC:       rdata_ff <= src_ff[bus_ch];
                    `OFS_DST:       rdata_ff <= dst_ff[bus_ch];
                    `OFS_SPLIT:     rdata_ff <= split_ff[bus_ch];
                    `OFS_COUNT:     rdata_ff <= {fcur_ff[bus_ch], ecur_ff[bus_ch]};
                    `OFS_INDEX:     rdata_ff <= idx_ff[bus_ch];
                    default:        rdata_ff <= `RST_ZERO;
                endcase
            end
        end
    end
    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = wreq_ff;

    // engine
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NCH; i++) begin
                prim_ff[i] <= `RST_ZERO; sec_ff[i] <= 4'h0; src_ff[i] <= `RST_ZERO;
                dst_ff[i] <= `RST_ZERO; split_ff[i] <= `RST_ZERO; cnt_ff[i] <= `RST_ZERO;
                ecur_ff[i] <= 16'h0; rxcur_ff[i] <= 16'h0; fcur_ff[i] <= 16'h0;
                idx_ff[i] <= `RST_ZERO; data_ff[i] <= `RST_ZERO;
                st_ff[i] <= dma_split_pkg::ST_IDLE;
            end
            rpend_ff <= '0; wpend_ff <= '0; irq_st_ff <= '0; irq_mk_ff <= '0;
            cur_ff <= 2'h0; busy_ff <= 1'b0; frame_event <= '0;
            mem_req <= 1'b0; mem_we <= 1'b0; mem_addr <= `RST_ZERO;
            mem_wdata <= `RST_ZERO; mem_size <= 2'h0; mem_peripheral_bus <= 1'b0;
            cpu_peripheral_bus_gnt <= 1'b0; irq <= 1'b0;
        end else begin
            frame_event <= '0;
            // clear first so a frame end in the same cycle wins
            if (wr_stat)
                irq_st_ff <= irq_st_ff & ~avs_writedata[NCH-1:0];
            if (wr_fire && is_chan) begin
                case (bus_reg)
                    `OFS_PRIMARY: begin
                        prim_ff[bus_ch] <= avs_writedata;
                        if (avs_writedata[`PRI_START_BIT] && (st_ff[bus_ch] == dma_split_pkg::ST_IDLE
                            || st_ff[bus_ch] == dma_split_pkg::ST_DONE)) begin
                            st_ff[bus_ch]    <= dma_split_pkg::ST_TX_RD;
                            ecur_ff[bus_ch]  <= cnt_ff[bus_ch][15:0];
                            rxcur_ff[bus_ch] <= cnt_ff[bus_ch][15:0];
                            fcur_ff[bus_ch]  <= cnt_ff[bus_ch][31:16];
                        end
                    end
                    `OFS_SECONDARY: sec_ff[bus_ch][`SEC_IE_BIT] <= avs_writedata[`SEC_IE_BIT];
                    `OFS_SRC:   src_ff[bus_ch]   <= avs_writedata;
                    `OFS_DST:   dst_ff[bus_ch]   <= avs_writedata;
                    `OFS_SPLIT: split_ff[bus_ch] <= avs_writedata;
                    `OFS_COUNT: cnt_ff[bus_ch]   <= avs_writedata;
                    `OFS_INDEX: idx_ff[bus_ch]   <= avs_writedata;
                    default: ;
                endcase
            end
            if (wr_fire && is_chan && bus_reg == `OFS_SECONDARY && avs_writedata[`SEC_FRAME_BIT])
                sec_ff[bus_ch][`SEC_FRAME_BIT] <= 1'b0;
            if (wr_mask)
                irq_mk_ff <= avs_writedata[NCH-1:0];
            if (!busy_ff) begin
                if (pick_ok && !(cpu_wins && mem_peripheral_bus)) begin
                    cur_ff  <= pick;
                    busy_ff <= 1'b1;
                end
                cpu_peripheral_bus_gnt <= cpu_peripheral_bus_req;
            end else begin
                // an outstanding dma peripheral access is never cut short
                cpu_peripheral_bus_gnt <= cpu_peripheral_bus_req & ~(mem_req & mem_peripheral_bus);
                case (st_ff[cur_ff])
                    // transmit half, source to split destination
                    dma_split_pkg::ST_TX_RD: begin
                        if (!mem_req && (!c_sync || rpend_ff[cur_ff]) && !(cpu_wins && c_peripheral_bus)) begin
                            mem_req <= 1'b1; mem_we <= 1'b0; mem_size <= c_esz;
                            mem_addr <= src_ff[cur_ff];
                            mem_peripheral_bus <= src_ff[cur_ff][31:28] == 4'h1;
                        end else if (mem_go) begin
                            mem_req <= 1'b0; data_ff[cur_ff] <= mem_rdata;
                            rpend_ff[cur_ff] <= 1'b0;
                            src_ff[cur_ff] <= src_ff[cur_ff] + s_step;
                            st_ff[cur_ff] <= c_split ? dma_split_pkg::ST_TX_WR : dma_split_pkg::ST_RX_WR;
                        end
                    end
                    dma_split_pkg::ST_TX_WR: begin
                        if (!mem_req && !(cpu_wins && c_spbus)) begin
                            mem_req <= 1'b1; mem_we <= 1'b1; mem_addr <= split_ff[cur_ff];
                            mem_wdata <= data_ff[cur_ff]; mem_peripheral_bus <= c_spbus;
                        end else if (mem_go) begin
                            mem_req <= 1'b0;
                            // transmit write end of frame leaves destination untouched
                            ecur_ff[cur_ff] <= ecur_ff[cur_ff] - 16'h1;
                            st_ff[cur_ff] <= (ecur_ff[cur_ff] <= 16'h1) ? dma_split_pkg::ST_RX_RD
                                                                     : dma_split_pkg::ST_TX_RD;
                            busy_ff <= 1'b0;
                        end
                    end
                    // receive half resumes from its own state after pause
                    dma_split_pkg::ST_RX_RD: begin
                        if (!mem_req && !(cpu_wins && c_rxsrc[31:28] == 4'h1)) begin
                            mem_req <= 1'b1; mem_we <= 1'b0; mem_addr <= c_rxsrc;
                            mem_peripheral_bus <= c_rxsrc[31:28] == 4'h1;
                        end else if (mem_go) begin
                            mem_req <= 1'b0; data_ff[cur_ff] <= mem_rdata;
                            st_ff[cur_ff] <= dma_split_pkg::ST_RX_WR;
                        end
                    end
                    dma_split_pkg::ST_RX_WR: begin
                        // receive write waits for its own sync event
                        if (!mem_req && (!c_sync || wpend_ff[cur_ff]) && !(cpu_wins && c_dpbus)) begin
                            mem_req <= 1'b1; mem_we <= 1'b1; mem_addr <= dst_ff[cur_ff];
                            mem_wdata <= data_ff[cur_ff];
                            mem_peripheral_bus <= dst_ff[cur_ff][31:28] == 4'h1;
                        end else if (mem_go) begin
                            mem_req <= 1'b0; wpend_ff[cur_ff] <= 1'b0; busy_ff <= 1'b0;
                            if (c_split) rxcur_ff[cur_ff] <= rxcur_ff[cur_ff] - 16'h1;
                            else ecur_ff[cur_ff] <= ecur_ff[cur_ff] - 16'h1;
                            if ((c_split ? rxcur_ff[cur_ff] : ecur_ff[cur_ff]) <= 16'h1) begin
                                dst_ff[cur_ff] <= dst_ff[cur_ff] + d_fstep;
                                sec_ff[cur_ff][`SEC_FRAME_BIT] <= 1'b1;
                                frame_event[cur_ff] <= sec_ff[cur_ff][`SEC_IE_BIT];
                                irq_st_ff[cur_ff] <= 1'b1;
                                fcur_ff[cur_ff] <= fcur_ff[cur_ff] - 16'h1;
                                ecur_ff[cur_ff] <= cnt_ff[cur_ff][15:0];
                                rxcur_ff[cur_ff] <= cnt_ff[cur_ff][15:0];
                                // no new transmit read after the last frame
                                st_ff[cur_ff] <= c_lastf ? dma_split_pkg::ST_DONE
                                                         : dma_split_pkg::ST_TX_RD;
                            end else begin
                                dst_ff[cur_ff] <= dst_ff[cur_ff] + d_step;
                                st_ff[cur_ff] <= c_split ? dma_split_pkg::ST_RX_RD
                                                         : dma_split_pkg::ST_TX_RD;
                            end
                        end
                    end
                    default: busy_ff <= 1'b0;
                endcase
            end
            // a new sync event outranks consumption of the old one
            for (int k = 0; k < NCH; k++) begin
                if (r_edge[k])
                    rpend_ff[k] <= 1'b1;
                if (w_edge[k])
                    wpend_ff[k] <= 1'b1;
            end
            irq <= |(irq_st_ff & irq_mk_ff);
        end
    end
endmodule : dma_split_mode_channel

// File: design/dma_split_regs.svh
`ifndef DMA_SPLIT_REGS_SVH
`define DMA_SPLIT_REGS_SVH
// register word offsets (byte address / 4), per channel block of 8 words at 0x20*ch
`define OFS_PRIMARY     4'h0
`define OFS_SECONDARY   4'h1
`define OFS_SRC         4'h2
`define OFS_DST         4'h3
`define OFS_SPLIT       4'h4
`define OFS_COUNT       4'h5
`define OFS_INDEX       4'h6
`define OFS_GLOBAL      4'h7
// primary control fields
`define PRI_START_BIT   0
`define PRI_PAUSE_BIT   1
`define PRI_SPLIT_BIT   2
`define PRI_SYNC_BIT    3
`define PRI_PREC_BIT    4
`define PRI_ESIZE_LSB   5
`define PRI_SDIR_LSB    7
`define PRI_DDIR_LSB    9
// secondary control fields
`define SEC_FRAME_BIT   0
`define SEC_IE_BIT      1
`define SEC_DONE_BIT    2
`define SEC_ACTIVE_BIT  3
// address update modes
`define DIR_HOLD        2'h0
`define DIR_INC         2'h1
`define DIR_DEC         2'h2
`define DIR_INDEX       2'h3
// element size codes
`define ESIZE_WORD      2'h0
`define ESIZE_HALF      2'h1
`define ESIZE_BYTE      2'h2
// global interrupt registers (byte address)
`define ADR_IRQ_STATUS  8'h80
`define ADR_IRQ_MASK    8'h84
`define RST_ZERO        32'h0000_0000
`endif

// File: design/dma_split_pkg.sv
package dma_split_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_TX_RD,
        ST_TX_WR,
        ST_RX_RD,
        ST_RX_WR,
        ST_DONE
    } xfer_state_e;
endpackage : dma_split_pkg

// File: bench/dma_split_mode_channel_sva.sv
`timescale 1ns/1ps
module dma_split_chk #(
    parameter int NCH = 4
) (
    input wire logic           mclk,
    input wire logic           arst_n,
    input wire logic           avs_read,
    input wire logic           avs_write,
    input wire logic           avs_waitrequest,
    input wire logic           cpu_peripheral_bus_req,
    input wire logic           cpu_peripheral_bus_gnt,
    input wire logic           mem_req,
    input wire logic           mem_we,
    input wire logic [31:0]    mem_addr,
    input wire logic [31:0]    mem_wdata,
    input wire logic [1:0]     mem_size,
    input wire logic           mem_peripheral_bus,
    input wire logic           mem_ack,
    input wire logic [NCH-1:0] frame_event
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    idle_wait_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("waitrequest low without a request");
    bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered in one cycle");
    wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("memory request changed before ack");
    wdata_hold_a: assert property (mem_req && mem_we && !mem_ack |=> $stable(mem_wdata))
        else $error("write data changed before ack");
    size_code_a: assert property (mem_req |-> mem_size != 2'h3)
        else $error("illegal element size");
    peripheral_bus_flag_a: assert property (mem_req |-> mem_peripheral_bus == (mem_addr[31:28] == 4'h1))
        else $error("peripheral flag does not match address");
    gnt_drop_a: assert property (!cpu_peripheral_bus_req |=> !cpu_peripheral_bus_gnt)
        else $error("grant without cpu request");
    peripheral_bus_excl_a: assert property (cpu_peripheral_bus_gnt |-> !(mem_req && mem_peripheral_bus && mem_ack))
        else $error("dma peripheral access while cpu granted");
    event_pulse_a: assert property (|frame_event |=> !(|(frame_event & $past(frame_event))))
        else $error("frame event longer than one cycle");
endmodule : dma_split_chk
bind dma_split_mode_channel dma_split_chk #(.NCH(NCH)) chk (.mclk, .arst_n, .avs_read, .avs_write,
    .avs_waitrequest, .cpu_peripheral_bus_req, .cpu_peripheral_bus_gnt, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_size, .mem_peripheral_bus, .mem_ack, .frame_event);

// File: bench/dma_split_mem_model.sv
`timescale 1ns/1ps
module dma_split_mem_model (
    input  wire logic        mclk,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    input  wire logic [3:0]  lat,
    output logic             mem_ack,
    output logic [31:0]      mem_rdata
);
    logic [3:0]  wait_ff = 4'h0;
    logic [31:0] rd_q[$], wa_q[$], wd_q[$];
    initial mem_ack = 1'b0;
    initial mem_rdata = 32'h0000_0000;
    // ack after lat idle cycles; data line toggles when not answering
    always @(posedge mclk) begin
        if (mem_req && !mem_ack && wait_ff >= lat) begin
            mem_ack <= 1'b1;
            mem_rdata <= {~mem_addr[15:0], mem_addr[15:0]};
            wait_ff <= 4'h0;
            if (mem_we) begin
                wa_q.push_back(mem_addr);
                wd_q.push_back(mem_wdata);
            end else
                rd_q.push_back(mem_addr);
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_ff <= mem_req ? wait_ff + 4'h1 : 4'h0;
        end
    end
endmodule : dma_split_mem_model

// File: bench/dma_split_mode_channel_bench.sv
`timescale 1ns/1ps
`include "dma_split_regs.svh"
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
    $display("MISMATCH %s exp %h got %h", nm, exp, got); bad_count++; end end
module dma_split_mode_channel_bench;
    logic        mclk, arst_n, avs_read, avs_write, avs_waitrequest, irq, cpu_peripheral_bus_req;
    logic        cpu_peripheral_bus_gnt, mem_req, mem_we, mem_peripheral_bus, mem_ack, rd_on, wr_on;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, mem_addr, mem_wdata, mem_rdata, d;
    logic [3:0]  rd_sync, wr_sync, frame_event, lat;
    logic [1:0]  mem_size;
    int          bad_count, compares, cyc, ev[4];
    dma_split_mode_channel #(.NCH(4)) DUT (.mclk, .arst_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .rd_sync, .wr_sync, .cpu_peripheral_bus_req,
        .cpu_peripheral_bus_gnt, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_size, .mem_peripheral_bus, .mem_ack,
        .mem_rdata, .frame_event);
    dma_split_mem_model mem (.mclk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .lat, .mem_ack,
        .mem_rdata);
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // sync pulse trains, frame event counters, run limit
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        rd_sync <= (rd_on && cyc % 8 == 0) ? 4'hf : 4'h0;
        wr_sync <= (wr_on && cyc % 8 == 0) ? 4'hf : 4'h0;
        foreach (ev[i]) ev[i] <= ev[i] + int'(frame_event[i] === 1'b1);
        if (cyc == 60000) begin
            bad_count++;
            test_done();
        end
    end
    function automatic logic [31:0] pat(logic [31:0] a);
        return {~a[15:0], a[15:0]};
    endfunction : pat
    function automatic logic [31:0] prim(logic sp, sy, pr, logic [1:0] es, sd, dd);
        return 32'({dd, sd, es, pr, sy, sp, 1'b0, 1'b1});
    endfunction : prim
    function automatic bit has_wr(logic [31:0] a, logic [31:0] v);
        foreach (mem.wa_q[i]) if (mem.wa_q[i] === a && mem.wd_q[i] === v) return 1'b1;
        return 1'b0;
    endfunction : has_wr
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0)
            @(posedge mclk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask : bus
    task automatic cfg(input int ch, input logic [31:0] pr, sc, sr, ds, sp, cn, ix);
        logic [7:0] b;
        b = 8'(ch * 32);
        mem.rd_q.delete();
        mem.wa_q.delete();
        mem.wd_q.delete();
        bus(1, b + 8'h04, sc, d);
        bus(1, b + 8'h08, sr, d);
        bus(1, b + 8'h0c, ds, d);
        bus(1, b + 8'h10, sp, d);
        bus(1, b + 8'h14, cn, d);
        bus(1, b + 8'h18, ix, d);
        bus(1, b, pr, d);
    endtask : cfg
    task automatic wait_done(input int ch, input int nw);
        int n;
        n = 0;
        while (mem.wa_q.size() < nw && n < 3000) begin
            @(posedge mclk);
            n++;
        end
        d = 0;
        while (d[`SEC_DONE_BIT] !== 1'b1 && n < 3100) begin
            bus(0, 8'(ch * 32 + 4), 0, d);
            n++;
        end
        `CHK("done", 1'b1, d[`SEC_DONE_BIT])
        `CHK("writes", nw, mem.wa_q.size())
    endtask : wait_done
    task automatic t_regs();
        bus(0, 8'h00, 0, d);
        `CHK("primary_rst", 32'h0000_0000, d)
        bus(1, 8'h84, 32'h0000_000f, d);
        bus(0, 8'h84, 0, d);
        `CHK("mask_rw", 32'h0000_000f, d)
        bus(1, 8'ha0, 32'hffff_ffff, d);
        bus(0, 8'ha0, 0, d);
        `CHK("unmapped", 32'h0000_0000, d)
    endtask : t_regs
    task automatic t_sizes();
        int st[3] = '{2, 2, 1};
        int dt[3] = '{4, 2, 1};
        for (int k = 0; k < 3; k++) begin
            cfg(1, prim(0, 0, 0, 2'(k), k == 0 ? `DIR_INDEX : `DIR_INC, `DIR_INC), 0, 32'h100,
                32'h200, 0, {16'd1, 16'd3}, {16'h0, 16'h2});
            wait_done(1, 3);
            for (int i = 0; i < 3; i++) begin
                `CHK("src_addr", 32'h100 + st[k] * i, mem.rd_q[i])
                `CHK("dst_addr", 32'h200 + dt[k] * i, mem.wa_q[i])
            end
        end
    endtask : t_sizes
    task automatic t_split();
        logic [31:0] dl[4] = '{32'h800, 32'h808, 32'h848, 32'h850};
        int e0;
        for (int ch = 0; ch < 4; ch++) begin
            e0 = ev[ch];
            bus(1, 8'h84, 32'(ch != 3) << ch, d);
            cfg(ch, prim(1, 0, 0, `ESIZE_WORD, `DIR_INC, `DIR_INDEX), 32'h2, 32'h400, 32'h800,
                32'hc00, {16'd2, 16'd2}, {16'h40, 16'h8});
            wait_done(ch, 8);
            for (int k = 0; k < 4; k++) begin
                `CHK("tx_write", 1'b1, has_wr(32'hc00, pat(32'h400 + 4 * k)))
                `CHK("rx_write", 1'b1, has_wr(dl[k], pat(32'hc04)))
            end
            `CHK("frame_events", 2, ev[ch] - e0)
            bus(0, 8'(ch * 32 + 4), 0, d);
            `CHK("frame_flag", 1'b1, d[`SEC_FRAME_BIT])
            `CHK("irq_on", 1'(ch != 3), irq)
            bus(1, 8'(ch * 32 + 4), 32'h3, d);
            bus(1, 8'h80, 32'hf, d);
            @(posedge mclk);
            `CHK("irq_off", 1'b0, irq)
        end
    endtask : t_split
    task automatic t_pause();
        int n;
        n = 0;
        lat <= 4'h6;
        cfg(2, prim(1, 0, 0, `ESIZE_WORD, `DIR_INC, `DIR_INC), 0, 32'h400, 32'h800, 32'hc00,
            {16'd1, 16'd4}, 0);
        while (mem.rd_q.size() < 4 && n < 500) begin
            @(posedge mclk);
            n++;
        end
        bus(1, 8'h40, prim(1, 0, 0, `ESIZE_WORD, `DIR_INC, `DIR_INC) | 32'h2, d);
        repeat (40) @(posedge mclk);
        bus(1, 8'h40, prim(1, 0, 0, `ESIZE_WORD, `DIR_INC, `DIR_INC), d);
        wait_done(2, 8);
        `CHK("rx_resumed", 1'b1, has_wr(32'h80c, pat(32'hc04)))
        lat <= 4'h0;
    endtask : t_pause
    task automatic t_sync();
        rd_on <= 1'b1;
        cfg(1, prim(1, 1, 0, `ESIZE_WORD, `DIR_INC, `DIR_INC), 0, 32'h400, 32'h800, 32'hc00,
            {16'd2, 16'd2}, 0);
        repeat (300) @(posedge mclk);
        `CHK("rx_waits_sync", 1'b0, has_wr(32'h800, pat(32'hc04)))
        wr_on <= 1'b1;
        wait_done(1, 8);
        rd_on <= 1'b0;
        wr_on <= 1'b0;
    endtask : t_sync
    task automatic t_prec();
        for (int p = 0; p < 2; p++) begin
            cpu_peripheral_bus_req <= 1'b1;
            cfg(0, prim(0, 0, 1'(p), `ESIZE_WORD, `DIR_INC, `DIR_INC), 0, 32'h1000_0000,
                32'h100, 0, {16'd1, 16'd1}, 0);
            repeat (100) @(posedge mclk);
            `CHK("dma_wins", 1'(p), has_wr(32'h100, pat(32'h1000_0000)))
            `CHK("cpu_grant", 1'b1, cpu_peripheral_bus_gnt)
            cpu_peripheral_bus_req <= 1'b0;
            wait_done(0, 1);
        end
    endtask : t_prec
    task automatic test_done();
        if (bad_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    initial begin
        {arst_n, avs_read, avs_write, cpu_peripheral_bus_req, rd_on, wr_on} = '0;
        {avs_address, avs_writedata, rd_sync, wr_sync, lat} = '0;
        {bad_count, compares, cyc} = '0;
        ev = '{default: 0};
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        t_regs();
        t_sizes();
        t_split();
        t_pause();
        t_sync();
        t_prec();
        test_done();
    end
endmodule : dma_split_mode_channel_bench
